// ### dv/pbsel_chk.sv
// Purpose: Assertion checker for the port B pin mode select block
// Assumes: Wait-free APB slave, pin and peripheral outputs registered
// Notes:   Register shadows follow the software writes seen on the bus
`timescale 1ns/100ps
module pbsel_chk
  import pbsel_pkg::*;
(
  input wire logic                         mclk,
  input wire logic                         resetn,
  input wire pbsel_pkg::pbsel_apb_req_s    apb_req,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [5:0]                   pin_in,
  input wire logic [5:0]                   pin_out,
  input wire logic [5:0]                   pin_oe,
  input wire pbsel_pkg::pbsel_periph_out_s periph_out,
  input wire pbsel_pkg::pbsel_periph_in_s  periph_in
);
  // ------------------------------------------------------------------
  // Shadows and history
  // ------------------------------------------------------------------
  wire        [31:0] a  = apb_req.paddr;
  wire        [31:0] d  = apb_req.pwdata;
  wire               wr = pready && apb_req.psel && apb_req.pwrite;
  wire               mapped = a inside {PBSEL_DIR_OFS, PBSEL_MODE_OFS,
                       PBSEL_FUNC_OFS, PBSEL_DATA_OFS, PBSEL_BSET_OFS};
  logic       [5:1]  dir_sh, mode_sh, func_sh;
  logic       [5:0]  pin_q;
  logic       [1:0]  quiet;  // Outputs lag writes, so wait three edges
  logic              up;
  pbsel_periph_out_s po_q;
  wire        [5:1]  irq_sel = mode_sh & ~func_sh;
  wire        [5:1]  ser     = mode_sh & func_sh;
  wire        [2:0]  si_sel  = {ser[1], ser[4], ser[3]};
  wire               q3      = quiet == 2'h3;

  // Byte write at its own address, or one bit through the window
  function automatic logic [5:1] upd(logic [5:1] cur, logic [31:0] ofs,
                                     logic [1:0] sel);
    upd = cur;
    if (a == ofs)
      upd = d[5:1];
    if (a == PBSEL_BSET_OFS && d[5:4] == sel && d[2:0] inside {[1:5]})
      upd[d[2:0]] = d[8];
  endfunction

  // Shadow update at the same edge as the register commit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dir_sh  <= PBSEL_DIR_RST[5:1];
      mode_sh <= PBSEL_MODE_RST[5:1];
      func_sh <= PBSEL_FUNC_RST[5:1];
      quiet   <= 2'h0;
      up      <= 1'b0;
    end else begin
      up    <= 1'b1;
      pin_q <= pin_in;
      po_q  <= periph_out;
      quiet <= wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      if (wr) begin
        dir_sh  <= upd(dir_sh, PBSEL_DIR_OFS, PBSEL_SEL_DIR);
        mode_sh <= upd(mode_sh, PBSEL_MODE_OFS, PBSEL_SEL_MODE);
        func_sh <= upd(func_sh, PBSEL_FUNC_OFS, PBSEL_SEL_FUNC);
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable && pready;
  endsequence

  AST_PREADY_NEXT:
    assert property (s_setup |=> pready)
    else $error("no pready after setup");
  AST_MODE_READ:
    assert property (s_access ##0 (!apb_req.pwrite && a == PBSEL_MODE_OFS)
      |-> prdata == {26'h0, mode_sh, 1'b1})
    else $error("mode register read value wrong");
  AST_UNMAPPED:
    assert property (s_access ##0 !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_NMI_PIN:
    assert property (up |-> !pin_oe[0] && periph_in.nmi == $past(pin_in[0]))
    else $error("pin zero not a pure nmi input");
  AST_IRQ_ROUTE:
    assert property (q3 |->
      periph_in.irq == (~irq_sel | (irq_sel & pin_q[5:1])))
    else $error("interrupt routing wrong");
  AST_PORT_DIR:
    assert property (q3 |-> (pin_oe[5:1] & ~mode_sh) == (~dir_sh & ~mode_sh))
    else $error("port mode direction wrong");
  AST_SER_OUT:
    assert property (q3 |-> (!ser[5] || pin_oe[5] && pin_out[5] == po_q.sdo)
      && (!ser[2] || pin_oe[2] && pin_out[2] == po_q.txd)
      && (!ser[3] || pin_oe[3] == po_q.sck_oe))
    else $error("serial output routing wrong");
  AST_SER_IN:
    assert property (q3 |-> {periph_in.rxd, periph_in.sdi, periph_in.sck_in}
      == (~si_sel | (si_sel & {pin_q[1], pin_q[4], pin_q[3]})))
    else $error("serial input routing wrong");
endmodule

bind pbsel_top pbsel_chk pbsel_chk_inst (
  .mclk(mclk), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .periph_out(periph_out), .periph_in(periph_in));

// ### dv/pbsel_pins.sv
// Purpose: Outside devices sharing the port B pins
// Assumes: Outside drivers let go whenever the block drives a pin
// Notes:   No contention modelled; ext gives the undriven levels
`timescale 1ns/100ps
module pbsel_pins (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext,
  output logic      [5:0] pin_in
);
  // Wire level: the block where enabled, otherwise the outside device
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ### dv/pbsel_top_tb.sv
// Purpose: Self-checking bench for the port B pin mode select block
// Assumes: Wait-free APB slave, outputs registered
// Notes:   Pins loop back through the outside device model
`timescale 1ns/100ps
module pbsel_top_tb;
  import pbsel_pkg::*;
  logic              mclk, resetn, pready, pslverr, e, serm;
  logic [31:0]       prdata, r;
  logic [5:0]        pin_in, pin_out, pin_oe, x, eoe, eout;
  logic [4:0]        eirq;
  logic [2:0]        esi;
  int                n_fail, n_checks;
  pbsel_apb_req_s    apb_req;
  pbsel_periph_out_s periph_out;
  pbsel_periph_in_s  periph_in;

  pbsel_top pbsel_top_inst (
    .mclk(mclk), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_out(periph_out), .periph_in(periph_in));
  pbsel_pins pbsel_pins_inst (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext(x), .pin_in(pin_in));

  // ------------------------------------------------------------------
  // Clock and bus tasks
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Keep leaves psel up so the next setup follows with no idle cycle
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, input bit keep = 0);
    int n;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("BAD %0t no pready", $time);
      end_sim();
    end
    r = prdata;
    e = pslverr;
    if (!keep) begin
      apb_req <= '0;
      @(posedge mclk);
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] exp,
                    input logic err = 1'b0);
    xfer(a, 1'b0, 32'h0);
    chk(r, {24'h0, exp});
    chk(e, err);
  endtask

  task automatic bset(input logic [1:0] s, input logic [2:0] p,
                      input logic v, input bit keep = 0);
    xfer(PBSEL_BSET_OFS, 1'b1, {23'h0, v, 2'h0, s, 1'b0, p}, keep);
  endtask

  initial begin
    apb_req    = '0;
    periph_out = '0;
    x          = 6'h2a;
    resetn     = 1'b0;
    n_fail     = 0;
    n_checks   = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(PBSEL_DIR_OFS, PBSEL_DIR_RST);
    rd(PBSEL_MODE_OFS, 8'h01);
    rd(PBSEL_FUNC_OFS, 8'h00);
    rd(PBSEL_DATA_OFS, 8'h2a);
    $display("test reset values done");
    // Byte and single-bit access, fixed bits must not move
    xfer(PBSEL_MODE_OFS, 1'b1, 32'hff);
    rd(PBSEL_MODE_OFS, 8'h3f);
    xfer(PBSEL_MODE_OFS, 1'b1, 32'hc0);
    rd(PBSEL_MODE_OFS, 8'h01);
    for (int i = 0; i < 8; i++)
      bset(2'h1, i[2:0], 1'b1, 1'b1);
    bset(2'h1, 3'h0, 1'b0);
    rd(PBSEL_MODE_OFS, 8'h3f);
    bset(2'h1, 3'h5, 1'b0);
    rd(PBSEL_MODE_OFS, 8'h1f);
    xfer(PBSEL_DIR_OFS, 1'b1, 32'h3e);
    bset(2'h0, 3'h3, 1'b0);
    rd(PBSEL_DIR_OFS, 8'h37);
    rd(PBSEL_BSET_OFS, 8'h37);
    xfer(32'hfffff448, 1'b1, 32'h0);
    chk(e, 1'b1);
    rd(32'hfffff448, 8'h00, 1'b1);
    rd(PBSEL_MODE_OFS, 8'h1f);
    $display("test register access done");
    // Port, interrupt, serial, port with stale function bits, then serial again
    xfer(PBSEL_DATA_OFS, 1'b1, 32'h3e);
    xfer(PBSEL_DIR_OFS, 1'b1, 32'h00);
    for (int m = 0; m < 5; m++) begin
      serm = (m == 2 || m == 4);
      x          <= m[0] ? 6'h15 : 6'h2a;
      periph_out <= (m == 4) ? 4'b0010 : 4'b1001;
      xfer(PBSEL_MODE_OFS, 1'b1, (m == 1 || serm) ? 32'h3e : 32'h0);
      xfer(PBSEL_FUNC_OFS, 1'b1, (m > 1) ? 32'h3e : 32'h0);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      eoe  = serm ? {2'b10, periph_out.sck_oe, 3'b100}
                  : ((m == 1) ? 6'h00 : 6'h3e);
      eout = serm ? {periph_out.sdo, 1'b0, periph_out.sck_out,
                     periph_out.txd, 2'b00} : 6'h3e;
      eirq = (m == 1) ? x[5:1] : 5'h1f;
      esi  = serm ? {x[1], x[4], periph_out.sck_oe ? periph_out.sck_out
                                                   : x[3]} : 3'h7;
      chk(pin_oe, eoe);
      chk(pin_out & pin_oe, eout & eoe);
      chk(periph_in.irq, eirq);
      chk({periph_in.rxd, periph_in.sdi, periph_in.sck_in}, esi);
      chk(periph_in.nmi, x[0]);
      @(posedge mclk);
      xfer(PBSEL_DATA_OFS, 1'b0, 32'h0);
      chk(r, {26'h0, 5'h1f, x[0]});
    end
    $display("test pin routing done");
    // Single-bit writes to function and data, function read back through the window
    bset(2'h2, 3'h2, 1'b0);
    rd(PBSEL_FUNC_OFS, 8'h3a);
    rd(PBSEL_BSET_OFS, 8'h3a);
    bset(2'h3, 3'h1, 1'b0);
    rd(PBSEL_DATA_OFS, 8'h3c);
    $display("test single-bit window done");
    end_sim();
  end
endmodule

// ### hdl/pbsel_pin_cell.sv
// Purpose: One port B pin: picks port, interrupt or serial use
// Assumes: Mode and function bits already registered
// Notes:   Purely combinational, outputs registered by the parent
`timescale 1ns/100ps
module pbsel_pin_cell (
  input  wire logic mode_bit,
  input  wire logic func_bit,
  input  wire logic dir_in,
  input  wire logic port_out,
  input  wire logic ser_out,
  input  wire logic ser_oe,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      irq_en,
  output logic      ser_en
);
  import pbsel_pkg::*;

  // ----------------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------------
  // Function select counts only in control mode
  wire pbsel_fn_e fn = !mode_bit ? PBSEL_FN_PORT :
                       (func_bit ? PBSEL_FN_SERIAL : PBSEL_FN_IRQ);

  // Interrupt and serial inputs leave the pin undriven
  assign irq_en  = (fn == PBSEL_FN_IRQ);
  assign ser_en  = (fn == PBSEL_FN_SERIAL);
  assign pin_out = ser_en ? ser_out : port_out;
  assign pin_oe  = ser_en ? ser_oe : (!mode_bit && !dir_in);

endmodule

// ### hdl/pbsel_pkg.sv
// Purpose: Constants and carrier types for the port B pin mode select block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses within the block window
package pbsel_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] PBSEL_DIR_OFS  = 32'hfffff424; // Direction
  localparam logic [31:0] PBSEL_MODE_OFS = 32'hfffff444; // Mode control
  localparam logic [31:0] PBSEL_FUNC_OFS = 32'hfffff464; // Function select
  localparam logic [31:0] PBSEL_DATA_OFS = 32'hfffff404; // Port data
  localparam logic [31:0] PBSEL_BSET_OFS = 32'hfffff480; // Single-bit access

  // ----------------------------------------------------------------------
  // Reset values and fixed bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] PBSEL_DIR_RST  = 8'hff; // All pins input
  localparam logic [7:0] PBSEL_MODE_RST = 8'h01;
  localparam logic [7:0] PBSEL_FUNC_RST = 8'h00;
  localparam logic [7:0] PBSEL_DATA_RST = 8'h00;
  localparam logic [7:0] PBSEL_MODE_FIX = 8'h01; // Bit 0 held at one
  localparam logic [7:0] PBSEL_MODE_MSK = 8'h3e; // Writable mode bits
  localparam logic [7:0] PBSEL_FUNC_MSK = 8'h3e;
  localparam logic [7:0] PBSEL_DIR_MSK  = 8'h3e; // Pin 0 input only
  localparam logic [7:0] PBSEL_DATA_MSK = 8'h3e;

  // ----------------------------------------------------------------------
  // Single-bit access word fields
  // ----------------------------------------------------------------------
  localparam int PBSEL_BIT_POS_LSB = 0;  // Bit number, 3 bits
  localparam int PBSEL_BIT_SEL_LSB = 4;  // Register select, 2 bits
  localparam int PBSEL_BIT_VAL_POS = 8;  // Value to write

  // Register select codes used by the single-bit write and read paths
  typedef enum logic [1:0] {
    PBSEL_SEL_DIR,
    PBSEL_SEL_MODE,
    PBSEL_SEL_FUNC,
    PBSEL_SEL_DATA
  } pbsel_sel_e;

  // Per-pin function chosen by the mux
  typedef enum logic [1:0] {
    PBSEL_FN_PORT,
    PBSEL_FN_IRQ,
    PBSEL_FN_SERIAL
  } pbsel_fn_e;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pbsel_apb_req_s;

  // Serial and interrupt peripheral side
  typedef struct packed {
    logic sdo;       // Sync serial data out
    logic sck_out;   // Sync serial clock out
    logic sck_oe;    // Sync serial clock driven (master)
    logic txd;       // Async transmit
  } pbsel_periph_out_s;

  typedef struct packed {
    logic [5:1] irq;  // External interrupt levels 1..5
    logic       nmi;  // Non-maskable interrupt level
    logic       sdi;  // Sync serial data in
    logic       sck_in;
    logic       rxd;
  } pbsel_periph_in_s;

endpackage

// ### hdl/pbsel_top.sv
// Purpose: Port B pin mode select with APB register access
// Assumes: mclk 100 MHz, resetn asynchronous active low, zero-wait APB
// Notes:   Pin 0 is input only and always feeds the non-maskable interrupt
//
// The APB register port was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - Direction register sets direction; mode and function bits pick use
// - Direction and mode registers take byte or single-bit access
// - Mode register at FFFFF444, resets 01, bits 7:6 zero, bit 0 one
// - Pin five: port mode, else interrupt input or sync serial out
// - Pin three: port mode, else interrupt input or sync serial clock
// - Pin two: port mode, else interrupt input or async transmit
// - Pin one: port mode, else interrupt input or async receive
// - Pin zero is input only NMI, level readable in data bit
// - Function select ignored while a pin is in port mode
// - Function bit clear selects interrupt, set selects serial function
module pbsel_top (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire pbsel_pkg::pbsel_apb_req_s   apb_req,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [5:0]                  pin_in,
  output logic [5:0]                       pin_out,
  output logic [5:0]                       pin_oe,
  input  wire pbsel_pkg::pbsel_periph_out_s periph_out,
  output pbsel_pkg::pbsel_periph_in_s      periph_in
);
  import pbsel_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] port_b_direction_reg;
  logic [7:0] port_b_mode_control_reg;
  logic [7:0] port_b_function_select_reg;
  logic [7:0] port_b_data_reg;
  logic [7:0] dir_next;
  logic [7:0] mode_next;
  logic [7:0] func_next;
  logic [7:0] data_next;
  logic [31:0] prdata_next;
  logic        pslverr_next;
  logic [5:0]  pin_out_next;
  logic [5:0]  pin_oe_next;
  pbsel_periph_in_s periph_in_next;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Setup-phase request; answer comes in the first access cycle
  wire setup_cyc = apb_req.psel && !apb_req.penable;
  wire access_cyc = apb_req.psel && apb_req.penable && pready;
  wire hit_dir  = (apb_req.paddr == PBSEL_DIR_OFS);
  wire hit_mode = (apb_req.paddr == PBSEL_MODE_OFS);
  wire hit_func = (apb_req.paddr == PBSEL_FUNC_OFS);
  wire hit_data = (apb_req.paddr == PBSEL_DATA_OFS);
  wire hit_bset = (apb_req.paddr == PBSEL_BSET_OFS);
  wire hit_any  = hit_dir | hit_mode | hit_func | hit_data | hit_bset;
  wire wr_en    = access_cyc && apb_req.pwrite && hit_any;

  // Single-bit access word: register select, bit number and value
  wire [2:0] bit_pos = apb_req.pwdata[PBSEL_BIT_POS_LSB +: 3];
  wire pbsel_sel_e bit_sel =
    pbsel_sel_e'(apb_req.pwdata[PBSEL_BIT_SEL_LSB +: 2]);
  wire       bit_val = apb_req.pwdata[PBSEL_BIT_VAL_POS];

  // Byte image after one bit is replaced
  function automatic logic [7:0] put_bit(input logic [7:0] cur,
                                         input logic [2:0] pos,
                                         input logic       val);
    logic [7:0] res;
    res      = cur;
    res[pos] = val;
    return res;
  endfunction

  // Live pin levels with the port data for output pins
  wire [7:0] data_view = {2'b00,
    (pin_in[5:1] & port_b_direction_reg[5:1]) |
    (port_b_data_reg[5:1] & ~port_b_direction_reg[5:1]),
    pin_in[0]};

  // Read select for the bit window, by the last written select field
  function automatic logic [7:0] reg_by_sel(input pbsel_sel_e s,
                                            input logic [7:0] d,
                                            input logic [7:0] m,
                                            input logic [7:0] f,
                                            input logic [7:0] v);
    case (s)
      PBSEL_SEL_DIR:  return d;
      PBSEL_SEL_MODE: return m;
      PBSEL_SEL_FUNC: return f;
      default:        return v;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------------
  // Fixed bits are forced on every write; direction bits 7:6 reset to one and any direction write clears them
  wire [7:0] dir_wdata = hit_bset ?
    put_bit(port_b_direction_reg, bit_pos, bit_val) :
    apb_req.pwdata[7:0];
  wire [7:0] mode_wdata = hit_bset ?
    put_bit(port_b_mode_control_reg, bit_pos, bit_val) :
    apb_req.pwdata[7:0];
  wire [7:0] func_wdata = hit_bset ?
    put_bit(port_b_function_select_reg, bit_pos, bit_val) :
    apb_req.pwdata[7:0];
  wire [7:0] data_wdata = hit_bset ?
    put_bit(port_b_data_reg, bit_pos, bit_val) :
    apb_req.pwdata[7:0];

  wire wr_dir  = wr_en && (hit_dir  || (hit_bset && bit_sel == PBSEL_SEL_DIR));
  wire wr_mode = wr_en && (hit_mode ||
                           (hit_bset && bit_sel == PBSEL_SEL_MODE));
  wire wr_func = wr_en && (hit_func ||
                           (hit_bset && bit_sel == PBSEL_SEL_FUNC));
  wire wr_data = wr_en && (hit_data ||
                           (hit_bset && bit_sel == PBSEL_SEL_DATA));

  // Pin 0 direction bit reads one: it can never be an output
  assign dir_next = wr_dir ?
    ((dir_wdata & PBSEL_DIR_MSK) | PBSEL_MODE_FIX) :
    port_b_direction_reg;
  assign mode_next = wr_mode ?
    ((mode_wdata & PBSEL_MODE_MSK) | PBSEL_MODE_FIX) :
    port_b_mode_control_reg;
  assign func_next = wr_func ? (func_wdata & PBSEL_FUNC_MSK) :
    port_b_function_select_reg;
  assign data_next = wr_data ? (data_wdata & PBSEL_DATA_MSK) :
    port_b_data_reg;

  // ----------------------------------------------------------------------
  // Read data and error answer
  // ----------------------------------------------------------------------
  // Bit window reads back the register chosen by the last select field
  logic [1:0] bit_rsel_reg;
  wire  [1:0] bit_rsel_next = (wr_en && hit_bset) ?
    apb_req.pwdata[PBSEL_BIT_SEL_LSB +: 2] : bit_rsel_reg;
  wire [7:0] rd_byte =
    hit_dir  ? port_b_direction_reg :
    hit_mode ? port_b_mode_control_reg :
    hit_func ? port_b_function_select_reg :
    hit_data ? data_view :
    reg_by_sel(pbsel_sel_e'(bit_rsel_reg), port_b_direction_reg,
               port_b_mode_control_reg, port_b_function_select_reg,
               data_view);
  assign prdata_next  = (setup_cyc && !apb_req.pwrite && hit_any) ?
    {24'h000000, rd_byte} : 32'h00000000;
  assign pslverr_next = setup_cyc && !hit_any;

  // ----------------------------------------------------------------------
  // Pin cells for pins 1..5
  // ----------------------------------------------------------------------
  wire [5:1] ser_out = {periph_out.sdo, 1'b0, periph_out.sck_out,
                        periph_out.txd, 1'b0};
  wire [5:1] ser_oe  = {1'b1, 1'b0, periph_out.sck_oe, 1'b1, 1'b0};
  wire [5:1] cell_out;
  wire [5:1] cell_oe;
  wire [5:1] cell_irq;
  wire [5:1] cell_ser;

  // Bit n of each register steers pin n
  genvar gi;
  generate
    for (gi = 1; gi <= 5; gi++) begin : g_pin
      pbsel_pin_cell u_cell (
        .mode_bit (port_b_mode_control_reg[gi]),
        .func_bit (port_b_function_select_reg[gi]),
        .dir_in   (port_b_direction_reg[gi]),
        .port_out (port_b_data_reg[gi]),
        .ser_out  (ser_out[gi]),
        .ser_oe   (ser_oe[gi]),
        .pin_out  (cell_out[gi]),
        .pin_oe   (cell_oe[gi]),
        .irq_en   (cell_irq[gi]),
        .ser_en   (cell_ser[gi])
      );
    end
  endgenerate

  // Pin 0 never drives
  assign pin_out_next = {cell_out, 1'b0};
  assign pin_oe_next  = {cell_oe, 1'b0};

  // Peripheral inputs idle high when their pin is not routed to them
  always_comb begin
    periph_in_next.nmi    = pin_in[0];
    periph_in_next.irq    = (pin_in[5:1] & cell_irq) | ~cell_irq;
    periph_in_next.rxd    = cell_ser[1] ? pin_in[1] : 1'b1;
    periph_in_next.sck_in = cell_ser[3] ? pin_in[3] : 1'b1;
    periph_in_next.sdi    = cell_ser[4] ? pin_in[4] : 1'b1;
  end
  // Pin 2 transmit and pin 5 data out leave via ser_out

  // ----------------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------------
  // Registers and bus answer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_b_direction_reg       <= PBSEL_DIR_RST;
      port_b_mode_control_reg    <= PBSEL_MODE_RST;
      port_b_function_select_reg <= PBSEL_FUNC_RST;
      port_b_data_reg            <= PBSEL_DATA_RST;
      bit_rsel_reg               <= 2'h0;
      prdata                     <= 32'h00000000;
      pready                     <= 1'b0;
      pslverr                    <= 1'b0;
    end else begin
      port_b_direction_reg       <= dir_next;
      port_b_mode_control_reg    <= mode_next;
      port_b_function_select_reg <= func_next;
      port_b_data_reg            <= data_next;
      bit_rsel_reg               <= bit_rsel_next;
      if (setup_cyc) begin
        prdata  <= prdata_next;
        pslverr <= pslverr_next;
      end
      pready <= setup_cyc;
    end
  end

  // Pin and peripheral outputs; one cycle behind the registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out   <= 6'h00;
      pin_oe    <= 6'h00;
      periph_in <= '1;
    end else begin
      pin_out   <= pin_out_next;
      pin_oe    <= pin_oe_next;
      periph_in <= periph_in_next;
    end
  end

endmodule
